// File: hdl/srm_map_select.sv
// Two-wire slave front end that decodes slave addresses and routes
// register accesses to the user, interrupt, second user or stream map.
// Assumes the sub-maps answer REG_ADDR_OK and REG_RDATA combinationally
// from REG_MAP and REG_ADDR on the same clock.
// Behaviour
// [R1] Selector bits 6:5 of 0x0e route sub-maps
// [R2] Second user map at main address, selector 10
// [R3] Selector resets to user sub-map
// [R4] Host writes selector back to 00
// [R5] Stream address from bits 7:1 of 0xfe
// [R6] Stream field resets zero; silent until nonzero
// [R7] Host programs stream address 0x88/0x89
// [R8] Stream map ignores pin and selector
// [R9] Select pin sets main address bit 1
// [R10] Unknown subaddress: no acknowledge, go idle
// [R11] Selector reachable from every main sub-map; applies next access
module srm_map_select (
  input wire logic MCLK,
  input wire logic SRST,
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  input wire logic ADDR_SELECT_PIN,
  output logic SDA_OUT,
  output logic SDA_OE_N,
  output srm_pkg::srm_map_e REG_MAP,
  output logic [7:0] REG_ADDR,
  output logic [7:0] REG_WDATA,
  output logic REG_WR,
  input wire logic REG_ADDR_OK,
  input wire logic [7:0] REG_RDATA,
  output logic [1:0] SUB_MAP_SELECTOR,
  output logic [6:0] STREAM_SLAVE_ADDR
);
  import srm_pkg::*;

  logic [2:0] sync_q;
  logic scl_s, sda_s, pin_s;
  logic scl_d_r, sda_d_r;
  logic scl_rise, scl_fall, start_ev, stop_ev;
  srm_state_e state_r;
  srm_phase_e phase_r;
  srm_map_e map_r, map_nxt;
  logic [3:0] bit_cnt_r;
  logic [7:0] shift_r, addr_r, wdata_r, sel_reg_r, stream_reg_r, txd;
  logic rw_r, stream_hit_r, wr_r, oe_n_r, sda_o_r;
  logic [1:0] sel_field, sel_out_r;
  logic [6:0] stream_out_r, sh_hi;
  logic [1:0] sh_sel;
  logic byte_done, dev_byte, dev_match_main, dev_match_str;
  logic int_sel, int_str, addr_ok, wr_fire;

  srm_sync #(.W(3), .RST_VAL(3'h6)) u_sync (
    .clk(MCLK),
    .srst(SRST),
    .d({SCL_IN, SDA_IN, ADDR_SELECT_PIN}),
    .q(sync_q)
  );
  assign scl_s = sync_q[2];
  assign sda_s = sync_q[1];
  assign pin_s = sync_q[0];

  always_ff @(posedge MCLK) begin
    if (SRST) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
    end
  end

  assign scl_rise = scl_s & ~scl_d_r;
  assign scl_fall = ~scl_s & scl_d_r;
  assign start_ev = scl_s & scl_d_r & sda_d_r & ~sda_s;
  assign stop_ev = scl_s & scl_d_r & ~sda_d_r & sda_s;

  assign sel_field = sel_reg_r[SEL_MSB:SEL_LSB];
  assign sh_hi = shift_r[7:1];
  assign sh_sel = shift_r[SEL_MSB:SEL_LSB];
  assign byte_done = (state_r == ST_RX) && scl_fall && (bit_cnt_r == 4'(BITS_PER_BYTE));
  assign dev_byte = byte_done && (phase_r == PH_DEV);
  assign dev_match_main = (sh_hi == {MAIN_ADDR_HI, pin_s}); // R9
  // Zero field means unprogrammed, so the stream map stays silent
  assign dev_match_str = (sh_hi == stream_reg_r[7:1])
                       && (stream_reg_r[7:1] != STREAM_ADDR_OFF); // R6 R8
  // Selector stays decodable in every main sub-map so the host can return
  assign int_sel = (map_r != MAP_STREAM) && (addr_r == SEL_REG_OFS); // R11
  assign int_str = (map_r == MAP_USER) && (addr_r == STREAM_REG_OFS); // R5
  assign addr_ok = int_sel | int_str | REG_ADDR_OK;
  assign wr_fire = (state_r == ST_CHK) && addr_ok && (phase_r == PH_DATA) && !start_ev && !stop_ev;
  assign txd = int_sel ? sel_reg_r : (int_str ? stream_reg_r : REG_RDATA);

  // Reserved selector code 11 falls back to the user sub-map
  always_comb begin
    if (stream_hit_r) begin
      map_nxt = MAP_STREAM; // R8
    end else begin
      unique case (sel_field)
        2'b01: map_nxt = MAP_INTR; // R1
        2'b10: map_nxt = MAP_USER2; // R2
        default: map_nxt = MAP_USER; // R1
      endcase
    end
  end

  // Byte engine
  always_ff @(posedge MCLK) begin
    if (SRST || stop_ev) begin
      state_r <= ST_IDLE;
      phase_r <= PH_DEV;
      bit_cnt_r <= 4'h0;
      shift_r <= 8'h00;
      rw_r <= 1'b0;
      stream_hit_r <= 1'b0;
    end else if (start_ev) begin
      state_r <= ST_RX;
      phase_r <= PH_DEV;
      bit_cnt_r <= 4'h0;
    end else begin
      unique case (state_r)
        ST_IDLE: ;
        ST_RX: begin
          if (scl_rise) begin
            shift_r <= {shift_r[6:0], sda_s};
            bit_cnt_r <= bit_cnt_r + 4'h1;
          end
          if (byte_done) begin
            if (phase_r == PH_DEV) begin
              rw_r <= shift_r[0];
              stream_hit_r <= !dev_match_main && dev_match_str;
              state_r <= (dev_match_main || dev_match_str) ? ST_ACK : ST_IDLE; // R6 R9
            end else begin
              state_r <= ST_CHK;
            end
          end
        end
        ST_CHK: state_r <= addr_ok ? ST_ACK : ST_IDLE; // R10
        ST_ACK: begin
          if (scl_fall) begin
            bit_cnt_r <= 4'h0;
            if (rw_r) begin
              state_r <= ST_TX;
              shift_r <= txd;
            end else begin
              state_r <= ST_RX;
              phase_r <= (phase_r == PH_DEV) ? PH_SUB : PH_DATA;
            end
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            shift_r <= {shift_r[6:0], 1'b0};
            bit_cnt_r <= bit_cnt_r + 4'h1;
            if (bit_cnt_r == 4'(BITS_PER_BYTE - 1)) begin
              state_r <= ST_RACK;
            end
          end
        end
        ST_RACK: begin
          if (scl_rise && sda_s) begin
            state_r <= ST_IDLE;
          end else if (scl_fall) begin
            state_r <= ST_TX;
            bit_cnt_r <= 4'h0;
            shift_r <= txd;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // Subaddress pointer; saturates so reads past the top repeat it
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      addr_r <= 8'h00;
    end else if (byte_done && phase_r == PH_SUB) begin
      addr_r <= shift_r;
    end else if (addr_r != SUBADDR_TOP && !start_ev && !stop_ev
                 && ((state_r == ST_ACK && scl_fall && !rw_r && phase_r == PH_DATA)
                     || (state_r == ST_RACK && scl_rise && !sda_s))) begin
      addr_r <= addr_r + 8'h01;
    end
  end

  // Local registers and the external write strobe
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      sel_reg_r <= SEL_REG_RST; // R3
      stream_reg_r <= STREAM_REG_RST; // R6
      wr_r <= 1'b0;
      wdata_r <= 8'h00;
    end else begin
      wr_r <= wr_fire && !int_sel && !int_str;
      if (wr_fire) begin
        wdata_r <= shift_r;
      end
      if (wr_fire && int_sel) begin
        sel_reg_r <= shift_r; // R1 R11
      end
      if (wr_fire && int_str) begin
        stream_reg_r <= shift_r; // R5
      end
    end
  end

  // Open drain: only the enable moves, the data flop stays low
  always_ff @(posedge MCLK) begin
    if (SRST) begin
      oe_n_r <= 1'b1;
      sda_o_r <= 1'b0;
      map_r <= MAP_USER;
      sel_out_r <= 2'b00;
      stream_out_r <= STREAM_ADDR_OFF;
    end else begin
      oe_n_r <= !((state_r == ST_ACK) || (state_r == ST_TX && !shift_r[7]));
      sda_o_r <= 1'b0;
      map_r <= map_nxt; // R11
      sel_out_r <= sel_field;
      stream_out_r <= stream_reg_r[7:1];
    end
  end

  assign SDA_OUT = sda_o_r;
  assign SDA_OE_N = oe_n_r;
  assign REG_MAP = map_r;
  assign REG_ADDR = addr_r;
  assign REG_WDATA = wdata_r;
  assign REG_WR = wr_r;
  assign SUB_MAP_SELECTOR = sel_out_r;
  assign STREAM_SLAVE_ADDR = stream_out_r;

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (SRST);

  a_sel_reset_user: assert property ($fell(SRST) |-> SUB_MAP_SELECTOR == 2'b00 && REG_MAP == MAP_USER) // R3
    else $error("selector not user map after reset");
  a_map_route_intr: assert property (!stream_hit_r && sel_field == 2'b01 |=> REG_MAP == MAP_INTR) // R1
    else $error("selector 01 did not route to interrupt map");
  a_user2_route: assert property (!stream_hit_r && sel_field == 2'b10 |=> REG_MAP == MAP_USER2) // R2
    else $error("selector 10 did not route to second user map");
  a_stream_field_load: assert property (wr_fire && int_str |-> ##2 STREAM_SLAVE_ADDR == $past(sh_hi, 2)) // R5
    else $error("stream address not taken from bits 7:1");
  a_stream_gate_zero: assert property (dev_byte && stream_reg_r[7:1] == STREAM_ADDR_OFF && !dev_match_main
                                       |=> state_r == ST_IDLE) // R6
    else $error("answered stream address while unprogrammed");
  a_stream_any_sel: assert property (dev_byte && dev_match_str && !dev_match_main
                                     |=> state_r == ST_ACK && stream_hit_r ##1 REG_MAP == MAP_STREAM) // R8
    else $error("stream map not selected on its address");
  a_main_addr_pin: assert property (dev_byte && sh_hi == {MAIN_ADDR_HI, pin_s}
                                    |=> state_r == ST_ACK && !stream_hit_r) // R9
    else $error("main address with select pin not acknowledged");
  a_bad_sub_nack: assert property (state_r == ST_CHK && !addr_ok && !start_ev && !stop_ev
                                   |=> state_r == ST_IDLE ##1 SDA_OE_N) // R10
    else $error("unknown subaddress was acknowledged");
  a_sel_reach_write: assert property (wr_fire && int_sel |-> ##2 SUB_MAP_SELECTOR == $past(sh_sel, 2)) // R11
    else $error("selector write not applied");

  c_stream_access: cover property (stream_hit_r && wr_r);
  c_user2_write: cover property (map_r == MAP_USER2 && wr_r);
  c_bad_sub: cover property (state_r == ST_CHK && !addr_ok);
  c_read_byte: cover property (state_r == ST_RACK && scl_rise && !sda_s);
endmodule : srm_map_select

// File: hdl/srm_pkg.sv
// Constants and types for the serial register map selector.
// Assumes one 200 MHz clock and a slow two-wire bus sampled on it.
package srm_pkg;
  localparam int unsigned BITS_PER_BYTE = 8;
  // Main slave address: upper six bits fixed, low bit from the select pin
  localparam logic [5:0] MAIN_ADDR_HI = 6'h10;
  // Sub-map selector register and its field
  localparam logic [7:0] SEL_REG_OFS = 8'h0e;
  localparam int unsigned SEL_LSB = 5;
  localparam int unsigned SEL_MSB = 6;
  localparam logic [7:0] SEL_REG_RST = 8'h00;
  // Stream-map slave address register, field in bits 7:1
  localparam logic [7:0] STREAM_REG_OFS = 8'hfe;
  localparam logic [7:0] STREAM_REG_RST = 8'h00;
  localparam logic [6:0] STREAM_ADDR_OFF = 7'h00;
  localparam logic [7:0] SUBADDR_TOP = 8'hff;

  typedef enum logic [1:0] {
    MAP_USER = 2'b00,
    MAP_INTR = 2'b01,
    MAP_USER2 = 2'b10,
    MAP_STREAM = 2'b11
  } srm_map_e;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RX = 3'b001,
    ST_CHK = 3'b011,
    ST_ACK = 3'b010,
    ST_TX = 3'b110,
    ST_RACK = 3'b111
  } srm_state_e;

  typedef enum logic [1:0] {
    PH_DEV = 2'b00,
    PH_SUB = 2'b01,
    PH_DATA = 2'b11
  } srm_phase_e;
endpackage : srm_pkg

// File: hdl/srm_sync.sv
// Two-flop synchroniser for a group of asynchronous pin levels.
// Assumes each bit is an independent level; no word coherence.
module srm_sync #(
  parameter int unsigned W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;

  always_ff @(posedge clk) begin
    if (srst) begin
      meta_r <= RST_VAL;
      sync_r <= RST_VAL;
    end else begin
      meta_r <= d;
      sync_r <= meta_r;
    end
  end

  assign q = sync_r;
endmodule : srm_sync

// File: tb/srm_host.sv
// Two-wire bus master model that drives bus clock and data, sampling on the falling MCLK edge.
// Assumes the bench resolves the open-drain data wire with a pull-up.
module srm_host (
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic sda_drv
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  task automatic hw(input int n);
    repeat (n) @(negedge clk);
  endtask : hw
  // Doubles as repeated start
  task automatic start();
    sda_drv = 1'b1;
    hw(8);
    scl = 1'b1;
    hw(8);
    sda_drv = 1'b0;
    hw(8);
    scl = 1'b0;
    hw(2);
  endtask : start
  task automatic stop();
    sda_drv = 1'b0;
    hw(8);
    scl = 1'b1;
    hw(8);
    sda_drv = 1'b1;
    hw(8);
  endtask : stop
  // Data moves 2 cycles after the clock falls, so it never races the clock edge
  task automatic bit_x(input logic b, output logic r);
    sda_drv = b;
    hw(8);
    scl = 1'b1;
    hw(4);
    r = sda;
    hw(4);
    scl = 1'b0;
    hw(2);
  endtask : bit_x
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(b[i], r);
    end
    bit_x(1'b1, r);
    ack = !r;
  endtask : wbyte
  task automatic rbyte(output logic [7:0] b, input logic nack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, r);
      b[i] = r;
    end
    bit_x(nack, r);
  endtask : rbyte
endmodule : srm_host

// File: tb/tb_srm_map_select.sv
// Self-checking bench for slave address decode and sub-map selection.
// Assumes srm_host as master and a toy sub-map that lacks only 0xf0.
module tb_srm_map_select;
  timeunit 1ns;
  timeprecision 1ps;
  import srm_pkg::*;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic pin = 1'b0;
  logic scl, sda_drv, sda_out, sda_oe_n, reg_wr, reg_addr_ok;
  wire sda;
  srm_map_e reg_map, wr_map;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, wr_addr, wr_data;
  logic [1:0] sel;
  logic [6:0] stream;
  logic [2:0] acks;
  int wr_cnt = 0;
  int err_count = 0;
  int samples_checked = 0;
  always #2.5 mclk = ~mclk;
  assign sda = sda_drv & (sda_oe_n | sda_out);
  assign reg_addr_ok = reg_addr != 8'hf0;
  assign reg_rdata = reg_addr ^ {reg_map, 6'h25};
  always @(posedge mclk) begin
    if (reg_wr === 1'b1) begin
      wr_cnt <= wr_cnt + 1;
      wr_map <= reg_map;
      wr_addr <= reg_addr;
      wr_data <= reg_wdata;
    end
  end
  srm_host srm_host_inst (.clk(mclk), .sda(sda), .scl(scl), .sda_drv(sda_drv));
  srm_map_select srm_map_select_inst (.MCLK(mclk), .SRST(srst), .SCL_IN(scl), .SDA_IN(sda),
    .ADDR_SELECT_PIN(pin), .SDA_OUT(sda_out), .SDA_OE_N(sda_oe_n), .REG_MAP(reg_map),
    .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_ADDR_OK(reg_addr_ok),
    .REG_RDATA(reg_rdata), .SUB_MAP_SELECTOR(sel), .STREAM_SLAVE_ADDR(stream));
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] dev, input logic [7:0] sub, input logic [7:0] dat);
    srm_host_inst.start();
    srm_host_inst.wbyte(dev, acks[2]);
    srm_host_inst.wbyte(sub, acks[1]);
    srm_host_inst.wbyte(dat, acks[0]);
    srm_host_inst.stop();
  endtask : wr
  task automatic t_reset();
    check({6'h0, sel}, 8'h00);
    check({6'h0, reg_map}, 8'h00);
    check({1'h0, stream}, 8'h00);
    check({7'h0, sda_out}, 8'h00);
    check({7'h0, sda_oe_n}, 8'h01);
    $display("t_reset done");
  endtask : t_reset
  task automatic t_addr();
    wr(8'h00, 8'h20, 8'h11);
    check({5'h0, acks}, 8'h00);
    wr(8'h42, 8'h20, 8'h11);
    check({5'h0, acks}, 8'h00);
    wr(8'h40, 8'h20, 8'h11);
    check({5'h0, acks}, 8'h07);
    check(wr_data, 8'h11);
    pin = 1'b1;
    wr(8'h40, 8'h21, 8'h12);
    check({5'h0, acks}, 8'h00);
    wr(8'h42, 8'h21, 8'h12);
    check(wr_addr, 8'h21);
    pin = 1'b0;
    $display("t_addr done");
  endtask : t_addr
  task automatic t_sel();
    // Code 3 is reserved and must fall back to the user map
    for (int c = 0; c < 4; c++) begin
      wr(8'h40, 8'h0e, 8'(c << 5));
      check({6'h0, sel}, 8'(c));
      wr(8'h40, 8'h30, 8'(c + 'h50));
      check({6'h0, wr_map}, 8'(c % 3));
      check(wr_data, 8'(c + 'h50));
    end
    wr(8'h40, 8'h0e, 8'h00);
    check({6'h0, sel}, 8'h00);
    $display("t_sel done");
  endtask : t_sel
  task automatic t_stream();
    wr(8'h40, 8'hfe, 8'h88);
    check({1'h0, stream}, 8'h44);
    wr(8'h40, 8'h0e, 8'h20);
    pin = 1'b1;
    wr(8'h88, 8'h05, 8'h3c);
    check({5'h0, acks}, 8'h07);
    check({6'h0, wr_map}, {6'h0, MAP_STREAM});
    wr(8'h42, 8'h0e, 8'h00);
    pin = 1'b0;
    $display("t_stream done");
  endtask : t_stream
  task automatic t_bad();
    int n;
    n = wr_cnt;
    wr(8'h40, 8'hf0, 8'h77);
    check({5'h0, acks}, 8'h04);
    check(8'(wr_cnt - n), 8'h00);
    $display("t_bad done");
  endtask : t_bad
  task automatic t_read();
    logic a;
    logic [7:0] d;
    srm_host_inst.start();
    srm_host_inst.wbyte(8'h40, a);
    srm_host_inst.wbyte(8'h20, a);
    srm_host_inst.start();
    srm_host_inst.wbyte(8'h41, a);
    srm_host_inst.rbyte(d, 1'b1);
    srm_host_inst.stop();
    check(d, 8'h05);
    // Local stream register reads back, then pointer saturates at the top
    srm_host_inst.start();
    srm_host_inst.wbyte(8'h40, a);
    srm_host_inst.wbyte(8'hfe, a);
    srm_host_inst.start();
    srm_host_inst.wbyte(8'h41, a);
    srm_host_inst.rbyte(d, 1'b0);
    check(d, 8'h88);
    srm_host_inst.rbyte(d, 1'b0);
    check(d, 8'hda);
    srm_host_inst.rbyte(d, 1'b1);
    srm_host_inst.stop();
    check(d, 8'hda);
    $display("t_read done");
  endtask : t_read
  task automatic final_report();
    $display("checks=%0d mismatches=%0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : final_report
  // Whole run is near 12.0k cycles; this bound only trips on a hang
  initial begin
    #400000;
    err_count++;
    final_report();
  end
  initial begin
    repeat (6) @(negedge mclk);
    srst = 1'b0;
    repeat (4) @(negedge mclk);
    t_reset();
    t_addr();
    t_sel();
    t_stream();
    t_bad();
    t_read();
    final_report();
  end
endmodule : tb_srm_map_select
